// file: inc/irq_seq_pkg.sv
package irq_seq_pkg;
  // ----------------------------------------
  // Sources and levels
  // ----------------------------------------
  localparam int NUM_MASKABLE = 10;
  localparam int NUM_LEVELS = 5;
  localparam int SEQ_STATES = 16;
  localparam logic [15:0] NMI_VECTOR = 16'h0004;
  localparam logic [15:0] LEVEL_VEC_BASE = 16'h0008;
  localparam logic [15:0] LEVEL_VEC_STEP = 16'h0008;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] MASK_ADDR = 8'h04;
  localparam logic [7:0] FLAG_ADDR = 8'h08;
  localparam logic [7:0] STAT_ADDR = 8'h0C;
  localparam logic [7:0] PC_ADDR = 8'h10;
  localparam logic [7:0] PSW_ADDR = 8'h14;
  localparam logic [7:0] SP_ADDR = 8'h18;
  localparam logic [7:0] TEST_ADDR = 8'h1C;
  localparam logic [7:0] RET_ADDR = 8'h20;
  localparam int ADDR_W = 8;

  // CTRL write bits
  localparam int CTRL_EI_BIT = 0;
  localparam int CTRL_DI_BIT = 1;
  localparam int CTRL_BOUND_BIT = 2;
  localparam int CTRL_STOP_BIT = 3;
  localparam int CTRL_RETURN_FROM_INTERRUPT_INSTR_BIT = 4;
  // TEST write: select in low bits, bit 8 reports skip-if-clear
  localparam int TEST_SEL_NMI = 15;
  localparam int TEST_CLEAR_BIT = 8;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_PUSH,
    SEQ_POP
  } seq_e;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } stack_s;
endpackage

// file: design/interrupt_acknowledge_sequencer.sv
// Behaviour
// - At each instruction end a set nonmaskable flag is acknowledged and cleared
// - Nonmaskable acknowledge clears the enable flop
// - Nonmaskable save pushes status, PC high, PC low, then jumps to 0004H
// - Whole acknowledge sequence takes sixteen states
// - Nonmaskable right after maskable acknowledge is served first, returns there
// - Return pops PC low, PC high, then status word
// - Skip tests see live nonmaskable pin level, never the flag
// - Enable flop cleared without saving the old value
// - Maskable flags checked only while enabled, masked ones excluded
// - Internal flags set at once, external after filtered level
// - Only highest priority eligible request is acknowledged, others pend
// - Acknowledged flag cleared unless both partners of the level unmasked
// - Maskable acknowledge clears enable, pushes status and PC, jumps to vector
// - Pending requests taken after enable instruction if none higher
// - Both partners unmasked: level request is OR, flags stay set
// - Unmasked pending flag auto-cleared only if partner is masked
// - Both partners masked: flags pend, never acknowledged
// - Maskable sources gated by enable flop and per-source mask
// - Reset and stop entry set every mask bit
// - Reset clears flags; reset, acknowledge and stop clear enable flop
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
module interrupt_acknowledge_sequencer
  import irq_seq_pkg::*;
#(
  parameter int NUM_SRC = NUM_MASKABLE,
  parameter int FILTER_CYCLES = 12
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic NMI_N_I,
  input wire logic RISING_EDGE_IRQ_PIN_I,
  input wire logic FALLING_EDGE_IRQ_PIN_N_I,
  input wire logic [NUM_SRC-1:0] INTERNAL_REQ_I,
  output logic STACK_WE_O,
  output logic [7:0] STACK_ADDR_O,
  output logic [7:0] STACK_DATA_O,
  input wire logic [7:0] STACK_RDATA_I,
  output logic SEQ_BUSY_O,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // ----------------------------------------
  // Pin synchronisers and level filters
  // ----------------------------------------
  logic [2:0] nmi_sy_q, r_sy_q, f_sy_q;
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      nmi_sy_q <= 3'h7;
      r_sy_q <= 3'h0;
      f_sy_q <= 3'h7;
    end else begin
      nmi_sy_q <= {nmi_sy_q[1:0], NMI_N_I};
      r_sy_q <= {r_sy_q[1:0], RISING_EDGE_IRQ_PIN_I};
      f_sy_q <= {f_sy_q[1:0], FALLING_EDGE_IRQ_PIN_N_I};
    end
  end
  logic [2:0] act_raw;
  assign act_raw[0] = (nmi_sy_q[1] == nmi_sy_q[2]) ? ~nmi_sy_q[2] : 1'b0;
  assign act_raw[1] = (r_sy_q[1] == r_sy_q[2]) ? r_sy_q[2] : 1'b0;
  assign act_raw[2] = (f_sy_q[1] == f_sy_q[2]) ? ~f_sy_q[2] : 1'b0;

  // Active level must hold FILTER_CYCLES; fires once per activation
  logic [2:0] ext_set;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_filt
      logic [7:0] cnt_q;
      logic seen_q;
      always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
          cnt_q <= 8'h00;
          seen_q <= 1'b0;
        end else if (!act_raw[g]) begin
          cnt_q <= 8'h00;
          seen_q <= 1'b0;
        end else if (!seen_q) begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(FILTER_CYCLES - 1)) seen_q <= 1'b1;
        end
      end
      assign ext_set[g] = act_raw[g] && !seen_q && (cnt_q == 8'(FILTER_CYCLES - 1));
    end
  endgenerate

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go;
  assign S_AXI_AWREADY = !aw_q && !bvalid_q;
  assign S_AXI_WREADY = !w_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign wr_go = aw_q && w_q && !bvalid_q;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == CTRL_ADDR || a == MASK_ADDR || a == FLAG_ADDR || a == STAT_ADDR ||
           a == PC_ADDR || a == PSW_ADDR || a == SP_ADDR || a == TEST_ADDR ||
           a == RET_ADDR;
  endfunction

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Write strobes into the core (full-word writes assumed on low lane)
  logic wr_ctrl, wr_mask, wr_pc, wr_psw, wr_sp, wr_test;
  assign wr_ctrl = wr_go && awaddr_q == CTRL_ADDR && S_AXI_WSTRB != 4'h0;
  assign wr_mask = wr_go && awaddr_q == MASK_ADDR;
  assign wr_pc = wr_go && awaddr_q == PC_ADDR;
  assign wr_psw = wr_go && awaddr_q == PSW_ADDR;
  assign wr_sp = wr_go && awaddr_q == SP_ADDR;
  assign wr_test = wr_go && awaddr_q == TEST_ADDR;

  // ----------------------------------------
  // Interrupt state
  // ----------------------------------------
  seq_e seq_q;
  logic [4:0] step_q;
  logic ie_q, nmi_flag_q, stop_q, test_res_q;
  logic [NUM_SRC-1:0] flag_q, mask_q, flag_clr;
  logic [15:0] pc_q;
  logic [7:0] psw_q, sp_q;
  logic boundary, ret_req;
  assign boundary = wr_ctrl && wdata_q[CTRL_BOUND_BIT] && seq_q == SEQ_IDLE;
  assign ret_req = wr_ctrl && wdata_q[CTRL_RETURN_FROM_INTERRUPT_INSTR_BIT] && seq_q == SEQ_IDLE;

  // Source map: bits 4,5 are the external pair (level 2); pairs share a level
  logic [NUM_SRC-1:0] set_vec;
  always_comb begin
    set_vec = INTERNAL_REQ_I;
    set_vec[4] = ext_set[1];
    set_vec[5] = ext_set[2];
  end

  // Eligible request per level, picking lowest index level first
  logic [NUM_LEVELS-1:0] lvl_req;
  logic [2:0] win;
  logic any_mask;
  always_comb begin
    win = 3'd0;
    any_mask = 1'b0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      lvl_req[l] = (flag_q[2*l] && !mask_q[2*l]) || (flag_q[2*l+1] && !mask_q[2*l+1]);
    end
    for (int l = NUM_LEVELS - 1; l >= 0; l--) begin
      if (lvl_req[l]) begin
        win = 3'(l);
        any_mask = 1'b1;
      end
    end
  end

  always_comb begin
    flag_clr = '0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      if (3'(l) == win && !(mask_q[2*l] == 1'b0 && mask_q[2*l+1] == 1'b0)) begin
        flag_clr[2*l] = !mask_q[2*l];
        flag_clr[2*l+1] = !mask_q[2*l+1];
      end
    end
  end

  logic take_nmi, take_mi;
  assign take_nmi = boundary && nmi_flag_q;
  assign take_mi = boundary && !nmi_flag_q && ie_q && any_mask;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      flag_q <= '0;
    end else begin
      // Set wins over auto-clear so a fresh event is never lost
      flag_q <= (flag_q & ~(take_mi ? flag_clr : '0) &
                 ~((wr_test && !wdata_q[TEST_CLEAR_BIT] && wdata_q[3:0] < 4'(NUM_SRC)) ?
                   (NUM_SRC'(1) << wdata_q[3:0]) : '0)) | set_vec;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      nmi_flag_q <= 1'b0;
    end else if (ext_set[0]) begin
      nmi_flag_q <= 1'b1;
    end else if (take_nmi) begin
      nmi_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      mask_q <= '1;
      stop_q <= 1'b0;
    end else begin
      stop_q <= wr_ctrl && wdata_q[CTRL_STOP_BIT];
      if (wr_ctrl && wdata_q[CTRL_STOP_BIT]) begin
        mask_q <= '1;
      end else if (wr_mask) begin
        mask_q <= wdata_q[NUM_SRC-1:0];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ie_q <= 1'b0;
    end else if (take_nmi || take_mi || (wr_ctrl && wdata_q[CTRL_STOP_BIT])) begin
      ie_q <= 1'b0;
    end else if (wr_ctrl && wdata_q[CTRL_DI_BIT]) begin
      ie_q <= 1'b0;
    end else if (wr_ctrl && wdata_q[CTRL_EI_BIT]) begin
      ie_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      test_res_q <= 1'b0;
    end else if (wr_test) begin
      if (wdata_q[3:0] == 4'(TEST_SEL_NMI)) begin
        test_res_q <= nmi_sy_q[2] ^ wdata_q[TEST_CLEAR_BIT];
      end else if (wdata_q[3:0] < 4'(NUM_SRC)) begin
        test_res_q <= flag_q[wdata_q[3:0]] ^ wdata_q[TEST_CLEAR_BIT];
      end else begin
        test_res_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Save and restore sequencer
  // ----------------------------------------
  // Pushes occupy steps 1..3, jump at the last step
  logic [15:0] vec_q;
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      seq_q <= SEQ_IDLE;
      step_q <= 5'h0;
      vec_q <= 16'h0;
      pc_q <= 16'h0;
      psw_q <= 8'h0;
      sp_q <= 8'h0;
    end else begin
      case (seq_q)
        SEQ_IDLE: begin
          step_q <= 5'h0;
          if (take_nmi) begin
            vec_q <= NMI_VECTOR;
            seq_q <= SEQ_PUSH;
          end else if (take_mi) begin
            vec_q <= LEVEL_VEC_BASE + LEVEL_VEC_STEP * 16'(win);
            seq_q <= SEQ_PUSH;
          end else if (ret_req) begin
            seq_q <= SEQ_POP;
          end
          if (wr_pc) pc_q <= wdata_q[15:0];
          if (wr_psw) psw_q <= wdata_q[7:0];
          if (wr_sp) sp_q <= wdata_q[7:0];
        end
        SEQ_PUSH: begin
          step_q <= step_q + 5'h1;
          if (step_q <= 5'h2) sp_q <= sp_q - 8'h1;
          if (step_q == 5'(SEQ_STATES - 1)) begin
            // new vector is the saved return of a following nonmaskable
            pc_q <= vec_q;
            seq_q <= SEQ_IDLE;
          end
        end
        SEQ_POP: begin
          step_q <= step_q + 5'h1;
          if (step_q == 5'h1) pc_q[7:0] <= STACK_RDATA_I;
          if (step_q == 5'h2) pc_q[15:8] <= STACK_RDATA_I;
          if (step_q == 5'h3) begin
            psw_q <= STACK_RDATA_I;
            seq_q <= SEQ_IDLE;
          end
          // Step 0 only settles the address; each read then climbs past its byte
          if (step_q != 5'h0) sp_q <= sp_q + 8'h1;
        end
        default: seq_q <= SEQ_IDLE;
      endcase
    end
  end

  stack_s stk_q;
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      stk_q <= '0;
    end else begin
      stk_q.we <= seq_q == SEQ_PUSH && step_q <= 5'h2;
      stk_q.addr <= (seq_q == SEQ_PUSH) ? sp_q - 8'h1 : sp_q;
      case (step_q)
        5'h0: stk_q.data <= psw_q;
        5'h1: stk_q.data <= pc_q[15:8];
        default: stk_q.data <= pc_q[7:0];
      endcase
    end
  end
  assign STACK_WE_O = stk_q.we;
  assign STACK_ADDR_O = (seq_q == SEQ_POP) ? sp_q : stk_q.addr;
  assign STACK_DATA_O = stk_q.data;
  assign SEQ_BUSY_O = seq_q != SEQ_IDLE;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      case (S_AXI_ARADDR)
        CTRL_ADDR: rdata_q <= {30'h0, stop_q, ie_q};
        MASK_ADDR: rdata_q <= 32'(mask_q);
        FLAG_ADDR: rdata_q <= 32'(flag_q);
        STAT_ADDR: rdata_q <= {27'h0, test_res_q, nmi_sy_q[2], nmi_flag_q, seq_q};
        PC_ADDR: rdata_q <= {16'h0, pc_q};
        PSW_ADDR: rdata_q <= {24'h0, psw_q};
        SP_ADDR: rdata_q <= {24'h0, sp_q};
        RET_ADDR: rdata_q <= {16'h0, vec_q};
        default: rdata_q <= 32'h0;
      endcase
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// file: tb/seq_monitor.sv
module seq_monitor
  import irq_seq_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic STACK_WE_O,
  input wire logic [7:0] STACK_ADDR_O,
  input wire logic SEQ_BUSY_O,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic [31:0] S_AXI_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  logic [4:0] cnt_q;
  logic we_seen_q;
  // ----------------------------------------
  // Busy span helpers
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I || !SEQ_BUSY_O) cnt_q <= 5'h00;
    else cnt_q <= cnt_q + 5'h01;
  end
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I || !SEQ_BUSY_O) we_seen_q <= 1'b0;
    else we_seen_q <= we_seen_q | STACK_WE_O;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_len;
    $fell(SEQ_BUSY_O) && we_seen_q |-> cnt_q == 5'h10;
  endproperty
  a_len: assert property (p_len) else $error("save sequence not sixteen states");
  property p_first;
    $rose(STACK_WE_O) |-> $past(SEQ_BUSY_O);
  endproperty
  a_first: assert property (p_first) else $error("push before sequence start");
  property p_push3;
    $rose(STACK_WE_O) |-> STACK_WE_O [*3] ##1 !STACK_WE_O;
  endproperty
  a_push3: assert property (p_push3) else $error("push not three bytes");
  property p_addr_dec;
    STACK_WE_O && $past(STACK_WE_O) |-> STACK_ADDR_O == $past(STACK_ADDR_O) - 8'h01;
  endproperty
  a_addr_dec: assert property (p_addr_dec) else $error("push address not descending");
  property p_we_busy;
    STACK_WE_O |-> SEQ_BUSY_O;
  endproperty
  a_we_busy: assert property (p_we_busy) else $error("push outside sequence");
  property p_aw_block;
    S_AXI_BVALID |-> !S_AXI_AWREADY;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during response");
  property p_slverr;
    S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == 32'h00000000;
  endproperty
  a_slverr: assert property (p_slverr) else $error("error read data not zero");
  property p_rone;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
  endproperty
  a_rone: assert property (p_rone) else $error("read answer repeated");
  c_save: cover property ($fell(SEQ_BUSY_O) && we_seen_q);
  c_pop: cover property ($fell(SEQ_BUSY_O) && !we_seen_q);
  c_err: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
endmodule

// file: tb/stack_model.sv
module stack_model (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [256];
  // Pops read the addressed byte at once, as the core's stack RAM does
  always_ff @(posedge clk_i) begin
    if (we_i) mem_q[addr_i] <= data_i;
  end
  assign rdata_o = mem_q[addr_i];
endmodule

// file: tb/interrupt_acknowledge_sequencer_test.sv
module interrupt_acknowledge_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_seq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic nmi_n = 1'b1;
  logic rise_irq = 1'b0;
  logic [9:0] req = 10'h000;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic awr, wrdy, bv, arr, rv, we, busy;
  logic [1:0] br, rr;
  logic [1:0] last_br = 2'h0;
  logic [31:0] rdat;
  logic [7:0] sa, sd, srd;
  int error_cnt = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  interrupt_acknowledge_sequencer #(.FILTER_CYCLES(3)) dut_u (
    .CLK_I(clk), .RESETN_I(rst_n), .NMI_N_I(nmi_n), .RISING_EDGE_IRQ_PIN_I(rise_irq),
    .FALLING_EDGE_IRQ_PIN_N_I(1'b1), .INTERNAL_REQ_I(req), .STACK_WE_O(we),
    .STACK_ADDR_O(sa), .STACK_DATA_O(sd), .STACK_RDATA_I(srd), .SEQ_BUSY_O(busy),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rre));
  stack_model stk_u (.clk_i(clk), .we_i(we), .addr_i(sa), .data_i(sd), .rdata_o(srd));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge clk);
      if (!ga && awr === 1'b1) begin
        ga = 1'b1;
        awv <= 1'b0;
      end
      if (!gw && wrdy === 1'b1) begin
        gw = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    last_br = br;
    bre <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdat;
    r = rr;
    rre <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, d & m, e);
  endtask
  task automatic sc(input logic [7:0] a, input logic [7:0] e);
    chk("stack", {24'h000000, stk_u.mem_q[a]}, {24'h000000, e});
  endtask
  // Sixteen save states plus margin; the end is judged by the busy check
  task automatic bnd;
    wr(CTRL_ADDR, 32'h00000004);
    repeat (24) @(posedge clk);
    chk("busy", {31'h00000000, busy}, 32'h00000000);
  endtask
  task automatic pulse(input logic [9:0] v);
    req <= v;
    @(posedge clk);
    req <= 10'h000;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc("mask", MASK_ADDR, 32'h3FF, 32'h3FF);
    rc("flag", FLAG_ADDR, 32'h3FF, 32'h000);
    rc("ie", CTRL_ADDR, 32'h1, 32'h0);
    rd(8'h40, d, r);
    chk("resp", {30'h00000000, r}, {30'h00000000, RESP_SLVERR});
    wr(8'h40, 32'h00000000);
    chk("bresp", {30'h00000000, last_br}, {30'h00000000, RESP_SLVERR});
    wr(SP_ADDR, 32'h80);
    chk("bresp", {30'h00000000, last_br}, {30'h00000000, RESP_OKAY});
    wr(PC_ADDR, 32'h1234);
    wr(PSW_ADDR, 32'h5A);
    wr(MASK_ADDR, 32'h3FB);
    pulse(10'h004);
    rc("flag", FLAG_ADDR, 32'h3FF, 32'h004);
    bnd;
    rc("pc", PC_ADDR, 32'hFFFF, 32'h1234);
    wr(CTRL_ADDR, 32'h1);
    bnd;
    rc("pc", PC_ADDR, 32'hFFFF, 32'h0010);
    rc("flag", FLAG_ADDR, 32'h3FF, 32'h000);
    rc("ie", CTRL_ADDR, 32'h1, 32'h0);
    sc(8'h7F, 8'h5A);
    sc(8'h7E, 8'h12);
    sc(8'h7D, 8'h34);
    nmi_n <= 1'b0;
    repeat (12) @(posedge clk);
    nmi_n <= 1'b1;
    repeat (8) @(posedge clk);
    rc("nmi flag", STAT_ADDR, 32'h4, 32'h4);
    bnd;
    rc("pc", PC_ADDR, 32'hFFFF, 32'h0004);
    rc("nmi flag", STAT_ADDR, 32'h4, 32'h0);
    sc(8'h7B, 8'h00);
    sc(8'h7A, 8'h10);
    wr(TEST_ADDR, 32'h00F);
    rc("pin", STAT_ADDR, 32'h18, 32'h18);
    wr(TEST_ADDR, 32'h10F);
    rc("pin", STAT_ADDR, 32'h18, 32'h08);
    wr(CTRL_ADDR, 32'h10);
    repeat (24) @(posedge clk);
    rc("pc", PC_ADDR, 32'hFFFF, 32'h0010);
    wr(CTRL_ADDR, 32'h10);
    repeat (24) @(posedge clk);
    rc("pc", PC_ADDR, 32'hFFFF, 32'h1234);
    rc("psw", PSW_ADDR, 32'hFF, 32'h5A);
    wr(MASK_ADDR, 32'h3BC);
    pulse(10'h041);
    wr(CTRL_ADDR, 32'h1);
    bnd;
    rc("pc", PC_ADDR, 32'hFFFF, 32'h0008);
    rc("flag", FLAG_ADDR, 32'h3FF, 32'h041);
    wr(TEST_ADDR, 32'h000);
    rc("flag", FLAG_ADDR, 32'h3FF, 32'h040);
    wr(CTRL_ADDR, 32'h1);
    bnd;
    rc("pc", PC_ADDR, 32'hFFFF, 32'h0020);
    rc("flag", FLAG_ADDR, 32'h3FF, 32'h000);
    wr(MASK_ADDR, 32'h3FF);
    rise_irq <= 1'b1;
    repeat (12) @(posedge clk);
    rise_irq <= 1'b0;
    rc("flag", FLAG_ADDR, 32'h3FF, 32'h010);
    wr(CTRL_ADDR, 32'h1);
    bnd;
    rc("pc", PC_ADDR, 32'hFFFF, 32'h0020);
    wr(MASK_ADDR, 32'h3EF);
    bnd;
    rc("pc", PC_ADDR, 32'hFFFF, 32'h0018);
    rc("flag", FLAG_ADDR, 32'h3FF, 32'h000);
    // Maskable and nonmaskable both eligible at one boundary
    wr(MASK_ADDR, 32'h3FB);
    pulse(10'h004);
    wr(CTRL_ADDR, 32'h1);
    nmi_n <= 1'b0;
    repeat (12) @(posedge clk);
    nmi_n <= 1'b1;
    repeat (8) @(posedge clk);
    bnd;
    rc("pc", PC_ADDR, 32'hFFFF, 32'h0004);
    rc("flag", FLAG_ADDR, 32'h3FF, 32'h004);
    rc("nmi flag", STAT_ADDR, 32'h4, 32'h0);
    rc("ie", CTRL_ADDR, 32'h1, 32'h0);
    wr(CTRL_ADDR, 32'h1);
    wr(CTRL_ADDR, 32'h2);
    rc("ie", CTRL_ADDR, 32'h1, 32'h0);
    wr(CTRL_ADDR, 32'h1);
    wr(CTRL_ADDR, 32'h8);
    rc("mask", MASK_ADDR, 32'h3FF, 32'h3FF);
    rc("ie", CTRL_ADDR, 32'h1, 32'h0);
    give_verdict;
  end
  // Whole run is about five hundred cycles; this bounds any hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end
endmodule
bind interrupt_acknowledge_sequencer seq_monitor mon_u (
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .STACK_WE_O(STACK_WE_O), .STACK_ADDR_O(STACK_ADDR_O),
  .SEQ_BUSY_O(SEQ_BUSY_O), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RDATA(S_AXI_RDATA));
